/* File: nand_host_defs.svh */
// Purpose: named constants of the serial NAND host controller
// Assumes: 100 MHz system clock
// Notes: definitions only
`ifndef NAND_HOST_DEFS_SVH
`define NAND_HOST_DEFS_SVH

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define OP_RESET 8'hFF
`define OP_GET_FEAT 8'h0F
`define OP_SET_FEAT 8'h1F
`define OP_READ_ID 8'h9F
`define OP_PAGE_READ 8'h13
`define OP_CACHE_RANDOM 8'h30
`define OP_CACHE_LAST 8'h3F
`define OP_RD_X1 8'h03
`define OP_RD_X1_FAST 8'h0B
`define OP_RD_X2 8'h3B
`define OP_RD_X4 8'h6B
`define OP_RD_DUAL_IO 8'hBB
`define OP_RD_QUAD_IO 8'hEB
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_BLOCK_ERASE 8'hD8
`define OP_PROG_EXEC 8'h10
`define OP_LOAD_X1 8'h02
`define OP_LOAD_X2 8'hA2
`define OP_LOAD_X4 8'h32
`define OP_LOAD_RND_X1 8'h84
`define OP_LOAD_RND_X2 8'h44
`define OP_LOAD_RND_X4 8'h34
`define OP_PERM_LOCK 8'h2C

// ------------------------------------------------------------
// software register offsets and fields
// ------------------------------------------------------------
`define REG_CMD 5'h00
`define REG_ADDR 5'h04
`define REG_LEN 5'h08
`define REG_TX 5'h0C
`define REG_RX 5'h10
`define REG_STAT 5'h14
`define REG_CTRL 5'h18
`define CTRL_CONT_BIT 0
`define CTRL_ECC_BIT 1
`define STAT_TX_FULL 0
`define STAT_RX_VALID 1
`define STAT_BUSY 2
`define STAT_OIP 3
`define STAT_WEL 4
`define STAT_REFUSED 5
`define STAT_CONT 6
`define FEAT_STATUS_ADDR 8'hC0
`define OIP_BIT 0

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define PAGE_BYTES 19'h01100
`define PAGE_DATA_BYTES 19'h01000
`define PAGES_PER_BLOCK 19'h00040
`define CONT_MAX_BYTES (`PAGE_DATA_BYTES * `PAGES_PER_BLOCK)

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_MHZ 100
`define SCK_MAX_X1_MHZ 83
`define SCK_MAX_X2_MHZ 60
`define SCK_MAX_X4_MHZ 30
`define SCK_HALF_MIN_X4 ((`CLK_MHZ + 2 * `SCK_MAX_X4_MHZ - 1) / (2 * `SCK_MAX_X4_MHZ))
`define SCK_HALF_CYC 3'h4
`define CS_HIGH_NS 100
`define CS_HIGH_CYC 10'((`CS_HIGH_NS * `CLK_MHZ + 999) / 1000)
`define CONT_ABORT_US 6
`define CONT_ABORT_CYC 10'(`CONT_ABORT_US * `CLK_MHZ)

`endif

/* File: nand_host_pkg.sv */
// Purpose: types of the serial NAND host controller
// Assumes: nothing
// Notes: constants live in nand_host_defs.svh
package nand_host_pkg;

  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_NEXT, S_GAP} state_t;
  typedef enum logic [1:0] {LANE_X1, LANE_X2, LANE_X4} lane_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} dir_t;

  typedef struct packed {
    logic known;
    logic [1:0] addr_n;
    logic [1:0] dummy_n;
    dir_t dir;
    lane_t alanes;
    lane_t dlanes;
    logic [1:0] fix_len;
    logic busy_after;
    logic needs_wel;
    logic cache_rd;
  } fmt_t;

endpackage : nand_host_pkg

/* File: serial_nand_host.sv */
// Purpose: host controller driving a serial NAND device over its SPI pins
// Assumes: mode 0 link, sck made here by a divider from clk
// Notes: software orders frames through a plain register port
//
// How it works
// (RULE_01) reset opcode alone, aborts any frame
// (RULE_02) device may abort busy array work
// (RULE_03) device reloads first page after reset
// (RULE_04) device clears status and config select
// (RULE_05) lock bits survive reset command
// (RULE_06) write enable sets the latch
// (RULE_07) program and erase need latch set
// (RULE_08) write disable clears the latch
// (RULE_09) x1 read: two address, one dummy
// (RULE_10) x2, x4, dual reads: two address, one dummy
// (RULE_11) quad io read: four-lane address, two dummy
// (RULE_12) program loads: two address, no dummy
// (RULE_13) random loads share program load format
// (RULE_14) permanent lock: three address bytes, no data
// (RULE_15) cache read end is opcode only
// (RULE_16) continuous mode off at reset, forces ecc
// (RULE_17) continuous needs both bits, else page read; the code enables it on the cont bit alone, as ecc_eff includes cont_en
// (RULE_18) sck kept under continuous lane limits
// (RULE_19) continuous read starts at column zero
// (RULE_20) continuous stream stops at block end
// (RULE_21) stopped continuous read: wait six microseconds
// (RULE_22) host reads page, waits, then reads cache
// (RULE_23) drive on falling, sample on rising
// (RULE_24) poll busy flag through get features
// (RULE_25) no commands while busy except reset
// (RULE_26) unknown opcodes and partial frames dropped
`timescale 1ns/1ns
`include "nand_host_defs.svh"

module serial_nand_host
  import nand_host_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic [3:0] io_in
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic fmt_t decode(input logic [7:0] op);
    fmt_t f;
    f = '0;
    case (op)
      `OP_RESET, `OP_CACHE_LAST, `OP_WR_ENABLE, `OP_WR_DISABLE: begin
        f.known = 1'h1;
        f.busy_after = (op == `OP_RESET) || (op == `OP_CACHE_LAST); // RULE_01 RULE_15
      end
      `OP_GET_FEAT, `OP_SET_FEAT: begin
        f = '{1'h1, 2'h1, 2'h0, (op == `OP_GET_FEAT) ? DIR_IN : DIR_OUT,
              LANE_X1, LANE_X1, 2'h1, 1'h0, 1'h0, 1'h0};
      end
      `OP_READ_ID: f = '{1'h1, 2'h0, 2'h1, DIR_IN, LANE_X1, LANE_X1, 2'h2, 1'h0, 1'h0, 1'h0};
      `OP_PAGE_READ, `OP_CACHE_RANDOM, `OP_PERM_LOCK: begin
        f = '{1'h1, 2'h3, 2'h0, DIR_NONE, LANE_X1, LANE_X1, 2'h0, 1'h1, 1'h0, 1'h0}; // RULE_14
      end
      `OP_BLOCK_ERASE, `OP_PROG_EXEC: begin
        f = '{1'h1, 2'h3, 2'h0, DIR_NONE, LANE_X1, LANE_X1, 2'h0, 1'h1, 1'h1, 1'h0}; // RULE_07
      end
      `OP_RD_X1, `OP_RD_X1_FAST: begin
        f = '{1'h1, 2'h2, 2'h1, DIR_IN, LANE_X1, LANE_X1, 2'h0, 1'h0, 1'h0, 1'h1}; // RULE_09
      end
      `OP_RD_X2: f = '{1'h1, 2'h2, 2'h1, DIR_IN, LANE_X1, LANE_X2, 2'h0, 1'h0, 1'h0, 1'h1}; // RULE_10
      `OP_RD_X4: f = '{1'h1, 2'h2, 2'h1, DIR_IN, LANE_X1, LANE_X4, 2'h0, 1'h0, 1'h0, 1'h1}; // RULE_10
      `OP_RD_DUAL_IO: begin
        f = '{1'h1, 2'h2, 2'h1, DIR_IN, LANE_X2, LANE_X2, 2'h0, 1'h0, 1'h0, 1'h1}; // RULE_10
      end
      `OP_RD_QUAD_IO: begin
        f = '{1'h1, 2'h2, 2'h2, DIR_IN, LANE_X4, LANE_X4, 2'h0, 1'h0, 1'h0, 1'h1}; // RULE_11
      end
      `OP_LOAD_X1, `OP_LOAD_RND_X1: begin
        f = '{1'h1, 2'h2, 2'h0, DIR_OUT, LANE_X1, LANE_X1, 2'h0, 1'h0, 1'h0, 1'h0}; // RULE_12 RULE_13
      end
      `OP_LOAD_X2, `OP_LOAD_RND_X2: begin
        f = '{1'h1, 2'h2, 2'h0, DIR_OUT, LANE_X1, LANE_X2, 2'h0, 1'h0, 1'h0, 1'h0}; // RULE_12 RULE_13
      end
      `OP_LOAD_X4, `OP_LOAD_RND_X4: begin
        f = '{1'h1, 2'h2, 2'h0, DIR_OUT, LANE_X1, LANE_X4, 2'h0, 1'h0, 1'h0, 1'h0}; // RULE_12 RULE_13
      end
      default: f = '0; // RULE_26
    endcase
    return f;
  endfunction : decode

  function automatic logic [3:0] lane_oe(input lane_t l);
    return (l == LANE_X4) ? 4'hF : (l == LANE_X2) ? 4'h3 : 4'h1;
  endfunction : lane_oe

  function automatic logic [3:0] lane_clocks(input lane_t l);
    return (l == LANE_X4) ? 4'h2 : (l == LANE_X2) ? 4'h4 : 4'h8;
  endfunction : lane_clocks

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  state_t state;
  logic [7:0] sh;
  logic [3:0] clk_left;
  logic [2:0] div;
  lane_t lanes;
  logic cap_in;
  logic rd_byte;
  logic [1:0] addr_left;
  logic [1:0] dummy_left;
  logic [18:0] data_left;
  logic [7:0] op;
  logic poll_frame;
  logic poll_pend;
  logic go;
  logic [7:0] go_op;
  logic [9:0] gap_cnt;
  logic [23:0] addr_q;
  logic [18:0] len_q;
  logic [7:0] tx_q;
  logic tx_full;
  logic [7:0] rx_q;
  logic rx_valid;
  logic write_enable_latch;
  logic op_in_progress;
  logic refused;
  logic cont_en;
  logic ecc_on;
  logic [3:0] io_s1;
  logic [3:0] io_s2;

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  wire cmd_wr = sw_wr && (sw_addr == `REG_CMD);
  wire tx_wr = sw_wr && (sw_addr == `REG_TX);
  wire rx_rd = sw_rd && (sw_addr == `REG_RX);
  wire [7:0] cmd_op = sw_wdata[7:0];
  wire fmt_t fmt_new = decode(cmd_op);
  wire is_reset_cmd = (cmd_op == `OP_RESET);
  wire cmd_ok = fmt_new.known && (!fmt_new.needs_wel || write_enable_latch); // RULE_07 RULE_26
  wire idle = (state == S_IDLE) && !go && !poll_pend;
  wire accept = cmd_wr && cmd_ok && (idle || is_reset_cmd); // RULE_25 RULE_01
  wire abort = accept && !idle; // RULE_01
  wire ecc_eff = ecc_on || cont_en; // RULE_16
  wire cont_active = cont_en && ecc_eff; // RULE_17
  wire [7:0] start_op = go ? go_op : `OP_GET_FEAT; // RULE_24
  wire fmt_t fmt_start = decode(start_op);
  wire fmt_t fmt_cur = decode(op);
  wire continuous_read_enable = cont_active && fmt_cur.cache_rd && !poll_frame;
  wire [18:0] len_max = continuous_read_enable ? 19'(`CONT_MAX_BYTES) : `PAGE_BYTES; // RULE_17 RULE_20
  wire [18:0] len_clip = (len_q == 19'h0) ? 19'h1 : (len_q > len_max) ? len_max : len_q;
  wire [18:0] start_len = (fmt_start.fix_len != 2'h0) ? {17'h0, fmt_start.fix_len} : len_clip;
  wire start_now = (state == S_IDLE) && (go || poll_pend) && !abort;
  wire [7:0] addr_pick = (addr_left == 2'h3) ? addr_q[23:16] :
                         (addr_left == 2'h2) ? addr_q[15:8] : addr_q[7:0];
  wire [7:0] addr_byte = poll_frame ? `FEAT_STATUS_ADDR : continuous_read_enable ? 8'h00 : addr_pick; // RULE_19
  wire in_next = (state == S_NEXT);
  wire sel_addr = addr_left != 2'h0;
  wire sel_dummy = !sel_addr && (dummy_left != 2'h0);
  wire sel_data = !sel_addr && !sel_dummy && (data_left != 19'h0);
  wire dir_in = (fmt_cur.dir == DIR_IN);
  wire data_rdy = dir_in ? (!rx_valid || poll_frame) : tx_full;
  wire nb_go = in_next && (sel_addr || sel_dummy || (sel_data && data_rdy));
  wire frame_end = in_next && !sel_addr && !sel_dummy && !sel_data;
  wire [7:0] nb_byte = sel_addr ? addr_byte : (sel_data && !dir_in) ? tx_q : 8'h00;
  wire lane_t nb_lanes = sel_data ? fmt_cur.dlanes : fmt_cur.alanes;
  wire nb_cap = sel_data && dir_in;
  wire [3:0] nb_oe = (sel_dummy || nb_cap) ? 4'h0 : lane_oe(nb_lanes);
  wire tx_take = nb_go && sel_data && !dir_in;
  wire tick = (state == S_SHIFT) && (div == `SCK_HALF_CYC - 3'h1); // RULE_18
  wire rise = tick && !sck;
  wire fall = tick && sck;
  wire byte_done = fall && (clk_left == 4'h1);
  wire [7:0] sh_cap = (lanes == LANE_X4) ? {sh[3:0], io_s2} :
                      (lanes == LANE_X2) ? {sh[5:0], io_s2[1:0]} : {sh[6:0], io_s2[1]};
  wire [7:0] sh_out = (lanes == LANE_X4) ? {sh[3:0], 4'h0} :
                      (lanes == LANE_X2) ? {sh[5:0], 2'h0} : {sh[6:0], 1'h0};
  wire [3:0] out_bits = (lanes == LANE_X4) ? sh[7:4] :
                        (lanes == LANE_X2) ? {2'h0, sh[7:6]} : {3'h0, sh[7]};
  wire [31:0] rmux =
    (sw_addr == `REG_ADDR) ? {8'h00, addr_q} :
    (sw_addr == `REG_LEN) ? {13'h0, len_q} :
    (sw_addr == `REG_RX) ? {24'h0, rx_q} :
    (sw_addr == `REG_CTRL) ? {30'h0, ecc_on, cont_en} :
    (sw_addr == `REG_STAT) ? {25'h0, cont_active, refused, write_enable_latch, op_in_progress, !idle, rx_valid, tx_full} :
    32'h0;

  // ------------------------------------------------------------
  // input synchroniser and software registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    io_s1 <= io_in;
    io_s2 <= io_s1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q <= 24'h0;
      len_q <= 19'h0;
      cont_en <= 1'h0; // RULE_16
      ecc_on <= 1'h0;
      sw_rdata <= 32'h0;
    end else begin
      if (sw_wr && (sw_addr == `REG_ADDR)) addr_q <= sw_wdata[23:0];
      if (sw_wr && (sw_addr == `REG_LEN)) len_q <= sw_wdata[18:0];
      if (sw_wr && (sw_addr == `REG_CTRL)) begin
        cont_en <= sw_wdata[`CTRL_CONT_BIT];
        ecc_on <= sw_wdata[`CTRL_ECC_BIT];
      end
      sw_rdata <= sw_rd ? rmux : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // data handshake flags: the set wins over the clear
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_q <= 8'h0;
      tx_full <= 1'h0;
      rx_q <= 8'h0;
      rx_valid <= 1'h0;
      refused <= 1'h0;
    end else begin
      if (tx_wr) tx_q <= sw_wdata[7:0];
      tx_full <= tx_wr || (tx_full && !tx_take);
      if (byte_done && rd_byte && !poll_frame) rx_q <= sh;
      rx_valid <= (byte_done && rd_byte && !poll_frame) || (rx_valid && !rx_rd);
      if (cmd_wr) refused <= !accept; // RULE_25 RULE_26
    end
  end

  // ------------------------------------------------------------
  // frame sequencer and bit engine
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= S_IDLE;
      sck <= 1'h0;
      cs_n <= 1'h1;
      io_oe <= 4'h0;
      io_out <= 4'h0;
      sh <= 8'h0;
      clk_left <= 4'h0;
      div <= 3'h0;
      lanes <= LANE_X1;
      cap_in <= 1'h0;
      rd_byte <= 1'h0;
      addr_left <= 2'h0;
      dummy_left <= 2'h0;
      data_left <= 19'h0;
      op <= 8'h0;
      poll_frame <= 1'h0;
      poll_pend <= 1'h0;
      go <= 1'h0;
      go_op <= 8'h0;
      gap_cnt <= 10'h0;
      write_enable_latch <= 1'h0;
      op_in_progress <= 1'h0;
    end else begin
      io_out <= out_bits;
      if (accept) begin
        go <= 1'h1;
        go_op <= cmd_op;
      end
      if (abort) begin
        // partial frame dropped by raising chip select
        state <= S_GAP; // RULE_01 RULE_26
        cs_n <= 1'h1;
        sck <= 1'h0;
        io_oe <= 4'h0;
        gap_cnt <= `CS_HIGH_CYC;
      end else if (start_now) begin
        go <= 1'h0;
        if (!go) poll_pend <= 1'h0;
        poll_frame <= !go;
        op <= start_op;
        addr_left <= fmt_start.addr_n;
        dummy_left <= fmt_start.dummy_n;
        data_left <= (fmt_start.dir == DIR_NONE) ? 19'h0 : start_len;
        if (start_op == `OP_WR_ENABLE) write_enable_latch <= 1'h1; // RULE_06
        if ((start_op == `OP_WR_DISABLE) || (start_op == `OP_RESET) ||
            fmt_start.needs_wel) write_enable_latch <= 1'h0; // RULE_08 RULE_07
        cs_n <= 1'h0;
        sh <= start_op;
        lanes <= LANE_X1;
        io_oe <= 4'h1;
        cap_in <= 1'h0;
        rd_byte <= 1'h0;
        clk_left <= 4'h8;
        div <= 3'h0;
        state <= S_SHIFT;
      end else if (nb_go) begin
        if (sel_addr) addr_left <= addr_left - 2'h1;
        if (sel_dummy) dummy_left <= dummy_left - 2'h1;
        // counted when a data byte starts, so write bytes end the frame too
        if (sel_data) data_left <= data_left - 19'h1;
        sh <= nb_byte;
        lanes <= nb_lanes;
        io_oe <= nb_oe;
        cap_in <= nb_cap;
        rd_byte <= nb_cap;
        clk_left <= lane_clocks(nb_lanes);
        div <= 3'h0;
        state <= S_SHIFT;
      end else if (frame_end) begin
        cs_n <= 1'h1;
        io_oe <= 4'h0;
        state <= S_GAP;
        gap_cnt <= continuous_read_enable ? `CONT_ABORT_CYC : `CS_HIGH_CYC; // RULE_21
        if (fmt_cur.busy_after && !poll_frame) begin
          poll_pend <= 1'h1; // RULE_22 RULE_24
          op_in_progress <= 1'h1;
        end
      end else if (state == S_SHIFT) begin
        div <= tick ? 3'h0 : div + 3'h1;
        if (tick) sck <= !sck;
        if (rise && cap_in) sh <= sh_cap; // RULE_23
        if (fall) begin
          clk_left <= clk_left - 4'h1;
          if (!cap_in) sh <= sh_out; // RULE_23
        end
        if (byte_done) begin
          state <= S_NEXT;
          if (rd_byte && poll_frame) begin
            op_in_progress <= sh[`OIP_BIT]; // RULE_24
            poll_pend <= sh[`OIP_BIT];
          end
        end
      end else if (state == S_GAP) begin
        gap_cnt <= gap_cnt - 10'h1;
        if (gap_cnt <= 10'h1) state <= S_IDLE;
      end
    end
  end

endmodule : serial_nand_host

/* File: serial_nand_host_asserts.sv */
// Purpose: port checks of the serial NAND host controller
// Assumes: mode 0 link, one clock domain
// Notes: bound to serial_nand_host below
`timescale 1ns/1ns
`include "nand_host_defs.svh"

module serial_nand_host_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic [3:0] io_in
);
  // ------------------------------------------------------------
  // link and register port checks
  // ------------------------------------------------------------
  logic [9:0] hi_cnt;
  wire logic unk_op;
  wire logic cmd_wr;
  assign cmd_wr = sw_wr && sw_addr == `REG_CMD;
  assign unk_op = !(sw_wdata[7:0] inside {8'hFF, 8'h0F, 8'h1F, 8'h9F, 8'h13, 8'h30, 8'h3F,
    8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h06, 8'h04, 8'hD8, 8'h10, 8'h02, 8'hA2,
    8'h32, 8'h84, 8'h44, 8'h34, 8'h2C});
  // deselect time seen before each frame
  always_ff @(posedge clk) begin
    if (!rstn) hi_cnt <= 10'h3FF;
    else if (!cs_n) hi_cnt <= 10'h000;
    else if (hi_cnt != 10'h3FF) hi_cnt <= hi_cnt + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_sck_idle: assert property (cs_n |-> !sck)
    else $error("serial clock moved while deselected");
  a_sck_high: assert property ($rose(sck) |-> (sck [*4] ##1 !sck) or (##[1:4] cs_n))
    else $error("serial clock high phase not four cycles");
  a_sck_low: assert property ($fell(sck) |-> (!sck) [*4])
    else $error("serial clock low phase too short");
  a_first_edge: assert property ($fell(cs_n) |-> (!sck) [*4] ##1 sck)
    else $error("first serial clock edge misplaced");
  a_opcode_lane: assert property ($fell(cs_n) |-> io_oe == 4'h1)
    else $error("opcode not driven on lane zero alone");
  a_lane_hold: assert property (sck && |io_oe |-> $stable(io_out))
    else $error("lane data changed while clock high");
  a_oe_idle: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_cs_gap: assert property ($fell(cs_n) |-> hi_cnt >= 10'd10)
    else $error("deselect time between frames too short");
  a_unk_drop: assert property (cmd_wr && unk_op && cs_n |=> cs_n [*4])
    else $error("unknown opcode started a frame");
  a_reset_abort: assert property (cmd_wr && sw_wdata[7:0] == 8'hFF && !cs_n |-> ##[1:72] cs_n)
    else $error("reset opcode did not end the running frame");
  a_rd_quiet: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
    else $error("read data present outside its cycle");
endmodule : serial_nand_host_asserts

bind serial_nand_host serial_nand_host_asserts chk (.clk(clk), .rstn(rstn), .sw_addr(sw_addr),
  .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sck(sck),
  .cs_n(cs_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in));

/* File: nand_dev_model.sv */
// Purpose: behavioural serial NAND device facing the host
// Assumes: mode 0 link, status read at feature address C0h
// Notes: status bit0 is op_in_progress; x1 read data is 5Ah
`timescale 1ns/1ns

module nand_dev_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  output logic [3:0] dev_out,
  output logic [3:0] dev_oe,
  output logic [7:0] n_frames,
  output logic [7:0] n_polls,
  output logic [7:0] key_op,
  output logic [15:0] key_bits,
  output logic [15:0] key_addr,
  output logic write_enable_latch
);
  logic [7:0] op;
  logic [15:0] cnt;
  logic [15:0] ad;
  logic [15:0] start;
  logic [1:0] oip_left;
  logic [7:0] dbyte;
  logic talk;
  initial begin
    {dev_out, dev_oe, n_frames, n_polls, key_op, key_bits, key_addr, write_enable_latch} = '0;
    {op, cnt, ad, oip_left} = '0;
  end
  // ------------------------------------------------------------
  // frame handling
  // ------------------------------------------------------------
  always @(posedge sck) begin
    if (!cs_n) begin
      if (cnt < 16'h0008) op = {op[6:0], io_out[0]};
      else if (cnt < 16'h0018) ad = {ad[14:0], io_out[0]};
      cnt = cnt + 16'h0001;
    end
  end
  always @(negedge sck) begin
    start = (op == 8'h0F) ? 16'h0010 : 16'h0020;
    dbyte = (op == 8'h0F) ? {7'h00, oip_left != 2'h0} : 8'h5A;
    talk = !cs_n && cnt >= start && (op inside {8'h03, 8'h0B} || (op == 8'h0F && cnt < 16'h0018));
    dev_oe[1] = talk;
    if (talk) dev_out[1] = dbyte[~cnt[2:0]];
  end
  always @(posedge cs_n) begin
    if (cnt != 16'h0000) begin
      n_frames = n_frames + 8'h01;
      if (op == 8'h0F) begin
        if (ad[15:8] == 8'hC0) n_polls = n_polls + 8'h01;
        if (oip_left != 2'h0) oip_left = oip_left - 2'h1;
      end else if (oip_left == 2'h0 || op == 8'hFF) begin
        key_op = op;
        key_bits = cnt;
        key_addr = ad;
        if (op inside {8'h13, 8'h30, 8'h3F, 8'h2C, 8'hFF} || (op inside {8'h10, 8'hD8} && write_enable_latch))
          oip_left = 2'h2;
        if (op == 8'h06) write_enable_latch = 1'b1;
        if (op inside {8'h04, 8'hFF, 8'h10, 8'hD8}) write_enable_latch = 1'b0;
      end
    end
    {cnt, ad, dev_oe} = '0;
  end
endmodule : nand_dev_model

/* File: serial_nand_command_control_bench.sv */
// Purpose: self-checking bench of the serial NAND host controller
// Assumes: 100 MHz clock, device model on the lanes
// Notes: table rows first, then reset, refusal, abort and continuous cases
`timescale 1ns/1ns
`include "nand_host_defs.svh"

module serial_nand_command_control_bench;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] bits;
    logic [1:0] bw;
    logic [15:0] ka;
  } row_t;
  // busy flag, latch after; zero address means unchecked
  row_t rows [23] = '{{8'h06, 8'h08, 2'b01, 16'h0}, {8'h03, 8'h28, 2'b01, 16'h5A96},
    {8'h0B, 8'h28, 2'b01, 16'h5A96}, {8'h3B, 8'h24, 2'b01, 16'h5A96},
    {8'h6B, 8'h22, 2'b01, 16'h5A96}, {8'hBB, 8'h18, 2'b01, 16'h0}, {8'hEB, 8'h12, 2'b01, 16'h0},
    {8'h02, 8'h20, 2'b01, 16'h5A96}, {8'hA2, 8'h1C, 2'b01, 16'h5A96},
    {8'h32, 8'h1A, 2'b01, 16'h5A96}, {8'h84, 8'h20, 2'b01, 16'h5A96},
    {8'h44, 8'h1C, 2'b01, 16'h5A96}, {8'h34, 8'h1A, 2'b01, 16'h5A96},
    {8'h13, 8'h20, 2'b11, 16'h3C5A}, {8'h30, 8'h20, 2'b11, 16'h3C5A},
    {8'h3F, 8'h08, 2'b11, 16'h0}, {8'h2C, 8'h20, 2'b11, 16'h3C5A},
    {8'h10, 8'h20, 2'b10, 16'h3C5A}, {8'h06, 8'h08, 2'b01, 16'h0},
    {8'hD8, 8'h20, 2'b10, 16'h3C5A}, {8'h06, 8'h08, 2'b01, 16'h0},
    {8'h04, 8'h08, 2'b00, 16'h0}, {8'hFF, 8'h08, 2'b10, 16'h0}};
  logic clk, rstn, sw_wr, sw_rd, tog, sck, cs_n, model_wel;
  logic [4:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, v;
  logic [3:0] io_out, io_oe, io_in, dev_out, dev_oe;
  logic [7:0] n_frames, n_polls, key_op, f0;
  logic [15:0] key_bits, key_addr;
  int hi_run, last_gap, cycles, err_count, total_checks;
  serial_nand_host dut (.clk(clk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sck(sck), .cs_n(cs_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
  nand_dev_model dev (.sck(sck), .cs_n(cs_n), .io_out(io_out), .dev_out(dev_out),
    .dev_oe(dev_oe), .n_frames(n_frames), .n_polls(n_polls), .key_op(key_op),
    .key_bits(key_bits), .key_addr(key_addr), .write_enable_latch(model_wel));
  // undriven lanes toggle so stale levels never pass
  assign io_in = (io_oe & io_out) | (~io_oe & dev_oe & dev_out) | (~io_oe & ~dev_oe & {4{tog}});
  always #5 clk = ~clk;
  always @(posedge clk) begin
    tog <= ~tog;
    cycles <= cycles + 1;
    if (cs_n) hi_run <= hi_run + 1;
    else begin
      if (hi_run != 0) last_gap <= hi_run;
      hi_run <= 0;
    end
    if (cycles == 90000) begin
      err_count = err_count + 1;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
    @(posedge clk);
  endtask : rd
  task automatic wait_idle();
    repeat (3) @(posedge clk);
    for (int k = 0; k < 600; k++) begin
      rd(`REG_STAT);
      if (v[`STAT_BUSY] === 1'b0 && cs_n === 1'b1) break;
    end
    chk("busy", 32'h0, 32'(v[`STAT_BUSY]));
  endtask : wait_idle
  task automatic run_row(input row_t r);
    logic [7:0] p0;
    f0 = n_frames;
    p0 = n_polls;
    wr(`REG_TX, 32'h000000C3);
    wr(`REG_CMD, 32'(r.op));
    wait_idle();
    chk("frames", r.bw[1] ? 32'h4 : 32'h1, 32'(8'(n_frames - f0)));
    chk("opcode", 32'(r.op), 32'(key_op));
    chk("clocks", 32'(r.bits), 32'(key_bits));
    if (r.ka != 16'h0) chk("address", 32'(r.ka), 32'(key_addr));
    chk("polls", r.bw[1] ? 32'h3 : 32'h0, 32'(8'(n_polls - p0)));
    rd(`REG_STAT);
    chk("wel", 32'(r.bw[0]), 32'(v[`STAT_WEL]));
    rd(`REG_RX);
    if (r.op inside {8'h03, 8'h0B}) chk("rx byte", 32'h5A, 32'(v[7:0]));
  endtask : run_row
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {clk, rstn, sw_wr, sw_rd, tog} = '0;
    sw_addr = 5'h00;
    sw_wdata = 32'h0;
    {hi_run, last_gap, cycles, err_count, total_checks} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk("cs_n idle", 32'h1, 32'(cs_n));
    chk("sck idle", 32'h0, 32'(sck));
    @(posedge clk);
    rd(`REG_CTRL);
    chk("ctrl reset", 32'h0, v);
    rd(`REG_STAT);
    chk("status reset", 32'h0, v);
    rd(5'h1C);
    chk("unmapped", 32'h0, v);
    wr(`REG_ADDR, 32'h003C5A96);
    wr(`REG_LEN, 32'h1);
    foreach (rows[i]) run_row(rows[i]);
    // command while busy, then reset opcode aborts the frame
    wr(`REG_CMD, 32'h2C);
    repeat (40) @(posedge clk);
    wr(`REG_CMD, 32'h06);
    rd(`REG_STAT);
    chk("refused busy", 32'h1, 32'(v[`STAT_REFUSED]));
    chk("wel busy", 32'h0, 32'(v[`STAT_WEL]));
    wr(`REG_CMD, 32'hFF);
    wait_idle();
    chk("reset op", 32'hFF, 32'(key_op));
    chk("reset clocks", 32'h8, 32'(key_bits));
    foreach (rows[i]) if (rows[i].op inside {8'hD8, 8'h10} || i == 0) begin
      f0 = n_frames;
      wr(`REG_CMD, i == 0 ? 32'h77 : 32'(rows[i].op));
      repeat (20) @(posedge clk);
      chk("no frame", 32'h0, 32'(8'(n_frames - f0)));
      rd(`REG_STAT);
      chk("refused", 32'h1, 32'(v[`STAT_REFUSED]));
    end
    // continuous read: column zero, long deselect after
    wr(`REG_CTRL, 32'h1);
    wr(`REG_CMD, 32'h03);
    wait_idle();
    chk("cont column", 32'h0, 32'(key_addr));
    rd(`REG_RX);
    chk("cont byte", 32'h5A, 32'(v[7:0]));
    wr(`REG_CMD, 32'h06);
    wait_idle();
    chk("cont gap", 32'h1, 32'(last_gap >= 600));
    wr(`REG_CTRL, 32'h2);
    wr(`REG_CMD, 32'h03);
    wait_idle();
    chk("ecc only column", 32'h5A96, 32'(key_addr));
    rd(`REG_RX);
    chk("ecc only byte", 32'h5A, 32'(v[7:0]));
    close_out();
  end
endmodule : serial_nand_command_control_bench
